// ---- rtl/ps_fault_pkg.sv ----
// Package of offsets, fields and reset values for the power stage fault status block
package ps_fault_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_PWM_MODE0 = 8'h00;
   localparam logic [7:0] OFS_PWM_MODE1 = 8'h04;
   localparam logic [7:0] OFS_CHAN_CFG = 8'h08;
   localparam logic [7:0] OFS_SLOPE = 8'h0C;
   localparam logic [7:0] OFS_ZERO = 8'h10;
   localparam logic [7:0] OFS_VOUT_ST0 = 8'h14;
   localparam logic [7:0] OFS_VOUT_ST1 = 8'h18;
   localparam logic [7:0] OFS_IOUT_ST = 8'h1C;
   localparam logic [7:0] OFS_PADS = 8'h20;
   localparam logic [7:0] OFS_TEMP0 = 8'h24;
   localparam logic [7:0] OFS_TEMP1 = 8'h28;
   localparam logic [7:0] OFS_CTRL = 8'h2C;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_UV_EN = 0;
   localparam int BIT_MIN_PULSE = 1;
   localparam int BIT_DRV_MON = 5;
   localparam int BIT_OV = 7;
   localparam int BIT_UV = 4;
   localparam int BIT_IOUT_FLT = 3;
   localparam int BIT_READY0 = 14;
   localparam int BIT_READY1 = 15;
   localparam int BIT_RESET_CMD = 0;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_PWM_MODE = 8'h02;
   localparam logic [7:0] RST_CHAN_CFG = 8'h00;
   localparam logic [15:0] RST_SLOPE = 16'h0008;
   localparam logic [15:0] RST_ZERO = 16'h0258;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int SENSE_TEST_NS = 400;
   localparam int SENSE_TEST_CYC = (SENSE_TEST_NS * CLK_MHZ + 999) / 1000;
   localparam logic [4:0] SENSE_TEST_CNT = 5'(SENSE_TEST_CYC);
   localparam int MIN_PULSE_NS = 80;
   localparam logic [3:0] MIN_PULSE_CNT = 4'((MIN_PULSE_NS * CLK_MHZ + 999) / 1000);
endpackage : ps_fault_pkg

// ---- rtl/power_stage_fault_status.sv ----
// Power stage fault recognition, status flags, readiness, temperature and minimum pulse
`timescale 1ns/1ps
module power_stage_fault_status #(
   parameter int ADC_W = 12
) (
   input wire logic core_clk, // System clock 25 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic [1:0] stageFaultPin, // Fault level on each sense bus, async
   input wire logic [1:0] stageUvPin, // Stage UV level on each sense bus, async
   input wire logic driveMonBelowPin, // Drive monitor comparator at or below 1.22V, async
   input wire logic [1:0] voutOvPin, // Output overvoltage comparator, async
   input wire logic [1:0] voutUvPin, // Output undervoltage comparator, async
   input wire logic [1:0] senseOpenPin, // Open test result per sense line, async
   input wire logic [1:0] runCmd, // Channel commanded to run
   input wire logic [1:0] pwmIn, // PWM from the control loop
   input wire logic [ADC_W-1:0] adcBus0, // Monitor ADC sample of bus 0, in mV
   input wire logic [ADC_W-1:0] adcBus1, // Monitor ADC sample of bus 1, in mV
   output logic [1:0] pwmOut, // PWM to the power stages
   output logic [1:0] outEnable, // Output enable per channel
   output logic senseTestActive // Open sense test in progress
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {TEST, RUN} phase_t;
   typedef struct packed {
      phase_t phase;
      logic [4:0] testCnt;
      logic [1:0] openLatch;
      logic [1:0] ovOff;
      logic [10:0] sync1;
      logic [10:0] sync2;
      logic [7:0] pwmMode0;
      logic [7:0] pwmMode1;
      logic [7:0] chanCfg;
      logic [15:0] slope;
      logic [15:0] zero;
      logic [7:0] voutSt0;
      logic [7:0] voutSt1;
      logic [7:0] ioutSt;
      logic [15:0] temp0;
      logic [15:0] temp1;
      logic [1:0] pwmPrev;
      logic [3:0] stretch0;
      logic [3:0] stretch1;
      logic [1:0] pwmOut;
      logic [31:0] prdata;
   } state_t;
   state_t st, next_st;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Signed temperature in C: (bus mV - zero mV) / slope
   function automatic logic [15:0] calcTemp(input logic [ADC_W-1:0] mv, input logic [15:0] zmv,
                                            input logic [15:0] slp);
      logic signed [17:0] diff;
      logic signed [17:0] q;
      diff = $signed({2'b00, 16'(mv)}) - $signed({2'b00, zmv});
      q = (slp == 16'h0000) ? 18'sh00000 : diff / $signed({2'b00, slp});
      return q[15:0];
   endfunction

   logic [1:0] fault, stageUv, vOv, vUv, open;
   logic driveMon, driveUv;
   logic [1:0] uvEn, uvActive, ready;
   logic wr, rd;
   assign {open, vUv, vOv, driveUv, stageUv, fault} = st.sync2;
   assign driveMon = st.chanCfg[ps_fault_pkg::BIT_DRV_MON];
   // Both channels watch the drive monitor when active, and bus UV is then ignored on both
   always_comb begin
      uvEn[0] = driveMon | st.pwmMode0[ps_fault_pkg::BIT_UV_EN];
      uvEn[1] = ~driveMon & st.pwmMode1[ps_fault_pkg::BIT_UV_EN];
      uvActive[0] = driveMon ? driveUv : (uvEn[0] & stageUv[0]);
      uvActive[1] = driveMon ? driveUv : (uvEn[1] & stageUv[1]);
   end
   assign ready = ~(uvActive | fault);
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign pready = psel & penable;
   assign pslverr = 1'b0;
   assign prdata = st.prdata;
   assign pwmOut = st.pwmOut;
   assign outEnable = (st.phase == RUN && st.openLatch == 2'b00) ? ~st.ovOff : 2'b00;
   assign senseTestActive = (st.phase == TEST);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0] setV0, setV1, setI;
      logic fullReset;
      next_st = st;
      setV0 = 8'h00;
      setV1 = 8'h00;
      setI = 8'h00;
      fullReset = 1'b0;
      // Pin synchroniser, two flip-flops before any logic reads a pin
      next_st.sync1 = {senseOpenPin, voutUvPin, voutOvPin, driveMonBelowPin, stageUvPin, stageFaultPin};
      next_st.sync2 = st.sync1;
      // Open sense test runs after reset and after a full reset command; its verdict holds until the next of either
      unique case (st.phase)
         TEST: begin
            next_st.testCnt = st.testCnt + 5'h01;
            next_st.openLatch = st.openLatch | open;
            if (st.testCnt == ps_fault_pkg::SENSE_TEST_CNT) begin
               next_st.phase = RUN;
            end
         end
         RUN: begin
         end
         default: next_st.phase = TEST;
      endcase
      // Overvoltage latches off with no retry
      next_st.ovOff = st.ovOff | vOv | (fault & runCmd);
      // Status flag sources per channel
      setV0[ps_fault_pkg::BIT_OV] = vOv[0] | fault[0] | st.openLatch[0] | (uvActive[0] & runCmd[0]);
      setV0[ps_fault_pkg::BIT_UV] = vUv[0] | st.openLatch[0];
      setV1[ps_fault_pkg::BIT_OV] = vOv[1] | fault[1] | st.openLatch[1] | (uvActive[1] & runCmd[1]);
      setV1[ps_fault_pkg::BIT_UV] = vUv[1] | st.openLatch[1];
      setI[ps_fault_pkg::BIT_IOUT_FLT] = fault[0];
      setI[ps_fault_pkg::BIT_IOUT_FLT + 1] = fault[1];
      // Register writes; status clears by writing ones, set beats clear
      next_st.prdata = 32'h00000000;
      if (wr) begin
         unique case (paddr)
            ps_fault_pkg::OFS_PWM_MODE0: next_st.pwmMode0 = pwdata[7:0];
            ps_fault_pkg::OFS_PWM_MODE1: next_st.pwmMode1 = pwdata[7:0];
            ps_fault_pkg::OFS_CHAN_CFG: next_st.chanCfg = pwdata[7:0];
            ps_fault_pkg::OFS_SLOPE: next_st.slope = pwdata[15:0];
            ps_fault_pkg::OFS_ZERO: next_st.zero = pwdata[15:0];
            ps_fault_pkg::OFS_VOUT_ST0: next_st.voutSt0 = st.voutSt0 & ~pwdata[7:0];
            ps_fault_pkg::OFS_VOUT_ST1: next_st.voutSt1 = st.voutSt1 & ~pwdata[7:0];
            ps_fault_pkg::OFS_IOUT_ST: next_st.ioutSt = st.ioutSt & ~pwdata[7:0];
            ps_fault_pkg::OFS_CTRL: fullReset = pwdata[ps_fault_pkg::BIT_RESET_CMD];
            default: begin
            end
         endcase
      end
      next_st.voutSt0 = next_st.voutSt0 | setV0;
      next_st.voutSt1 = next_st.voutSt1 | setV1;
      next_st.ioutSt = next_st.ioutSt | setI;
      // Read data captured in setup, so the access phase never waits
      if (rd) begin
         unique case (paddr)
            ps_fault_pkg::OFS_PWM_MODE0: next_st.prdata = {24'h000000, st.pwmMode0};
            ps_fault_pkg::OFS_PWM_MODE1: next_st.prdata = {24'h000000, st.pwmMode1};
            ps_fault_pkg::OFS_CHAN_CFG: next_st.prdata = {24'h000000, st.chanCfg};
            ps_fault_pkg::OFS_SLOPE: next_st.prdata = {16'h0000, st.slope};
            ps_fault_pkg::OFS_ZERO: next_st.prdata = {16'h0000, st.zero};
            ps_fault_pkg::OFS_VOUT_ST0: next_st.prdata = {24'h000000, st.voutSt0};
            ps_fault_pkg::OFS_VOUT_ST1: next_st.prdata = {24'h000000, st.voutSt1};
            ps_fault_pkg::OFS_IOUT_ST: next_st.prdata = {24'h000000, st.ioutSt};
            ps_fault_pkg::OFS_PADS: next_st.prdata = {16'h0000, ready, 14'h0000};
            ps_fault_pkg::OFS_TEMP0: next_st.prdata = {16'h0000, st.temp0};
            ps_fault_pkg::OFS_TEMP1: next_st.prdata = {16'h0000, st.temp1};
            default: next_st.prdata = 32'h00000000;
         endcase
      end
      // Temperature refreshed every cycle, whether or not the bus is wired
      next_st.temp0 = calcTemp(adcBus0, st.zero, st.slope);
      next_st.temp1 = calcTemp(adcBus1, st.zero, st.slope);
      // Minimum pulse: a rising edge arms a counter that holds the output high
      next_st.pwmPrev = pwmIn;
      next_st.stretch0 = (pwmIn[0] & ~st.pwmPrev[0]) ? ps_fault_pkg::MIN_PULSE_CNT :
                         (st.stretch0 != 4'h0) ? st.stretch0 - 4'h1 : 4'h0;
      next_st.stretch1 = (pwmIn[1] & ~st.pwmPrev[1]) ? ps_fault_pkg::MIN_PULSE_CNT :
                         (st.stretch1 != 4'h0) ? st.stretch1 - 4'h1 : 4'h0;
      next_st.pwmOut[0] = outEnable[0] & (pwmIn[0] |
                          (st.pwmMode0[ps_fault_pkg::BIT_MIN_PULSE] & (st.stretch0 > 4'h1)));
      next_st.pwmOut[1] = outEnable[1] & (pwmIn[1] |
                          (st.pwmMode1[ps_fault_pkg::BIT_MIN_PULSE] & (st.stretch1 > 4'h1)));
      // Full reset command retests the sense lines and clears the open verdict and overvoltage shutdown
      if (fullReset) begin
         next_st.phase = TEST;
         next_st.testCnt = 5'h00;
         next_st.openLatch = 2'b00;
         next_st.ovOff = 2'b00;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '0;
         st.phase <= TEST;
         st.pwmMode0 <= ps_fault_pkg::RST_PWM_MODE;
         st.pwmMode1 <= ps_fault_pkg::RST_PWM_MODE;
         st.chanCfg <= ps_fault_pkg::RST_CHAN_CFG;
         st.slope <= ps_fault_pkg::RST_SLOPE;
         st.zero <= ps_fault_pkg::RST_ZERO;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Any open line keeps every output off
   property p_open_off;
      @(posedge core_clk) disable iff (!rst_n) (st.openLatch != 2'b00) |-> outEnable == 2'b00;
   endproperty
   a_open_off: assert property (p_open_off) else $error("outputs on with open line");

   // Any write to the control word may be a full reset, whatever its data
   logic fullResetSeen;
   assign fullResetSeen = wr && paddr == ps_fault_pkg::OFS_CTRL;

   // Shutdown holds until a full reset; a retry would restart into the fault
   property p_ov_sticky;
      @(posedge core_clk) disable iff (!rst_n) st.ovOff[1] && !fullResetSeen |=> st.ovOff[1];
   endproperty
   a_ov_sticky: assert property (p_ov_sticky) else $error("overvoltage off retried");

   // A retest lasts long enough for the synchronised pins to settle
   property p_test_len;
      @(posedge core_clk) disable iff (!rst_n) $rose(senseTestActive) |-> senseTestActive [*8];
   endproperty
   a_test_len: assert property (p_test_len) else $error("sense test too short");

   // The test ends as soon as its count is reached
   property p_test_end;
      @(posedge core_clk) disable iff (!rst_n)
         senseTestActive && st.testCnt == ps_fault_pkg::SENSE_TEST_CNT && !fullResetSeen |=> !senseTestActive;
   endproperty
   a_test_end: assert property (p_test_end) else $error("sense test overran");

   // Readiness reads back low while stage UV is active
   property p_ready0;
      @(posedge core_clk) disable iff (!rst_n)
         rd && paddr == ps_fault_pkg::OFS_PADS && uvActive[0] |=> !st.prdata[ps_fault_pkg::BIT_READY0];
   endproperty
   a_ready0: assert property (p_ready0) else $error("ch0 ready while stage uv");

   property p_ready;
      @(posedge core_clk) disable iff (!rst_n)
         rd && paddr == ps_fault_pkg::OFS_PADS && uvActive[1] |=> !st.prdata[ps_fault_pkg::BIT_READY1];
   endproperty
   a_ready: assert property (p_ready) else $error("ready while stage uv");

   // Disabled stage UV gives no indication
   property p_uv_gate0;
      @(posedge core_clk) disable iff (!rst_n)
         (!driveMon && !st.pwmMode0[ps_fault_pkg::BIT_UV_EN]) |-> !uvActive[0];
   endproperty
   a_uv_gate0: assert property (p_uv_gate0) else $error("ch0 uv active while disabled");

   property p_uv_gate;
      @(posedge core_clk) disable iff (!rst_n) (!driveMon && !st.pwmMode1[0]) |-> !uvActive[1];
   endproperty
   a_uv_gate: assert property (p_uv_gate) else $error("uv active while disabled");

   // The drive monitor owns channel 1 whenever it is selected
   property p_drive_ch1;
      @(posedge core_clk) disable iff (!rst_n) driveMon |-> uvActive[1] == driveUv;
   endproperty
   a_drive_ch1: assert property (p_drive_ch1) else $error("ch1 ignores drive monitor");

   // Drive UV on a running channel reports overvoltage
   property p_drive_run;
      @(posedge core_clk) disable iff (!rst_n)
         driveMon && driveUv && runCmd[1] |=> st.voutSt1[ps_fault_pkg::BIT_OV];
   endproperty
   a_drive_run: assert property (p_drive_run) else $error("drive uv not reported");

   // A stage fault sets both status words
   sequence s_fault;
      fault[1] && !st.openLatch[1];
   endsequence
   property p_fault_flags;
      @(posedge core_clk) disable iff (!rst_n) s_fault |=> st.voutSt1[7] && st.ioutSt[4];
   endproperty
   a_fault_flags: assert property (p_fault_flags) else $error("fault flags not set");

   // A stage fault on a running channel shuts its output at once
   property p_fault_off;
      @(posedge core_clk) disable iff (!rst_n) fault[1] && runCmd[1] |=> outEnable[1] == 1'b0;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("output on after fault");

   // Output UV and open lines land in the status word
   property p_uv_flag0;
      @(posedge core_clk) disable iff (!rst_n) vUv[0] |=> st.voutSt0[ps_fault_pkg::BIT_UV];
   endproperty
   a_uv_flag0: assert property (p_uv_flag0) else $error("uv flag not set");

   property p_open_flags;
      @(posedge core_clk) disable iff (!rst_n)
         st.openLatch[0] |=> st.voutSt0[ps_fault_pkg::BIT_OV] && st.voutSt0[ps_fault_pkg::BIT_UV];
   endproperty
   a_open_flags: assert property (p_open_flags) else $error("open line flags not set");

   // An open verdict survives everything but a retest
   property p_open_hold;
      @(posedge core_clk) disable iff (!rst_n) st.openLatch[0] && !fullResetSeen |=> st.openLatch[0];
   endproperty
   a_open_hold: assert property (p_open_hold) else $error("open verdict lost");

   // Flags stay latched until the host writes a one
   property p_latched;
      @(posedge core_clk) disable iff (!rst_n) st.voutSt0[4] && !(wr && paddr == ps_fault_pkg::OFS_VOUT_ST0)
         |=> st.voutSt0[4];
   endproperty
   a_latched: assert property (p_latched) else $error("uv flag lost without clear");

   // A short pulse is held for the minimum width; narrower ones may be ignored by the stage
   sequence s_pulse_start;
      pwmIn[0] && !st.pwmPrev[0] && st.pwmMode0[ps_fault_pkg::BIT_MIN_PULSE] && outEnable[0];
   endsequence
   sequence s_pulse_kept;
      outEnable[0] && st.pwmMode0[ps_fault_pkg::BIT_MIN_PULSE];
   endsequence
   property p_min_pulse;
      @(posedge core_clk) disable iff (!rst_n)
         s_pulse_start ##1 s_pulse_kept |-> pwmOut[0] ##1 pwmOut[0];
   endproperty
   a_min_pulse: assert property (p_min_pulse) else $error("pulse shorter than minimum");
endmodule // power_stage_fault_status

// ---- dv/ps_stage_model.sv ----
// Model of the power stages sharing the temperature/fault buses
`timescale 1ns/1ps
module ps_stage_model (
   input wire logic core_clk, // System clock
   input wire logic [1:0] pwm, // PWM seen by the stages
   input wire logic [3:0] faultReq, // Fault per phase, two phases a bus
   input wire logic [3:0] uvReq, // Stage UV per phase
   output logic [1:0] faultBus, // Wire-OR fault level per bus
   output logic [1:0] uvBus, // Wire-OR UV level per bus
   output logic [3:0] lastWidth // Width of the last channel 0 pulse
);
   logic [3:0] run;
   // Any phase pulls its bus at once; the pins are asynchronous anyway
   assign faultBus = {|faultReq[3:2], |faultReq[1:0]};
   assign uvBus = {|uvReq[3:2], |uvReq[1:0]};
   // Measure each channel 0 pulse so that a too narrow one is visible
   always_ff @(posedge core_clk) begin
      if (pwm[0]) begin
         run <= run + 4'h1;
      end else begin
         if (run != 4'h0) begin
            lastWidth <= run;
         end
         run <= 4'h0;
      end
   end
endmodule // ps_stage_model

// ---- dv/power_stage_fault_status_bench.sv ----
// Self-checking bench for the power stage fault status block
`timescale 1ns/1ps
module power_stage_fault_status_bench;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, driveMonBelowPin = 1'b0;
   logic pready, pslverr, senseTestActive;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [1:0] stageFaultPin, stageUvPin, voutOvPin = 2'h0, voutUvPin = 2'h0, senseOpenPin = 2'h0;
   logic [1:0] runCmd = 2'h0, pwmIn = 2'h0, pwmOut, outEnable;
   logic [11:0] adcBus0 = 12'h258, adcBus1 = 12'h258;
   logic [3:0] faultReq = 4'h0, uvReq = 4'h0, lastWidth;
   int fails = 0, checks = 0, w, t, s;
   // 25 MHz system clock
   always #20 core_clk = ~core_clk;
   power_stage_fault_status #(.ADC_W(12)) DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stageFaultPin(stageFaultPin), .stageUvPin(stageUvPin),
      .driveMonBelowPin(driveMonBelowPin), .voutOvPin(voutOvPin), .voutUvPin(voutUvPin),
      .senseOpenPin(senseOpenPin), .runCmd(runCmd), .pwmIn(pwmIn), .adcBus0(adcBus0), .adcBus1(adcBus1),
      .pwmOut(pwmOut), .outEnable(outEnable), .senseTestActive(senseTestActive));
   ps_stage_model stages (.core_clk(core_clk), .pwm(pwmOut), .faultReq(faultReq), .uvReq(uvReq),
      .faultBus(stageFaultPin), .uvBus(stageUvPin), .lastWidth(lastWidth));
   // ----------------------------------------------------------------
   // Tasks and expectations
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      checks++;
      if (v !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, v);
      end
   endtask
   // One APB transfer, then one idle cycle so psel is never set twice in a step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      chk("pslverr", 32'h0, 32'(pslverr));
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         chk("pready wait", 32'h1, 32'h0);
         give_verdict();
      end
      @(posedge core_clk);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, q & m);
   endtask
   // Pins pass a two stage synchroniser before the flags move
   task automatic settle();
      repeat (5) @(posedge core_clk);
   endtask
   task automatic retest();
      int n;
      n = 0;
      while (senseTestActive !== 1'b1 && n < 8) begin
         @(posedge core_clk);
         n++;
      end
      while (senseTestActive !== 1'b0 && n < 48) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 48) begin
         chk("sense test end", 32'h1, 32'h0);
         give_verdict();
      end
   endtask
   function automatic logic [3:0] expW(input int wd, input logic on);
      if (on && wd < int'(ps_fault_pkg::MIN_PULSE_CNT)) begin
         return ps_fault_pkg::MIN_PULSE_CNT;
      end
      return 4'(wd);
   endfunction
   function automatic logic [15:0] expTemp(input logic [11:0] adc, input int sl);
      return 16'((int'(adc) - int'(ps_fault_pkg::RST_ZERO)) / sl);
   endfunction
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(45216));
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      retest();
      chk("enable after test", 32'h3, 32'(outEnable));
      rdchk("mode0", ps_fault_pkg::OFS_PWM_MODE0, 32'hFF, 32'(ps_fault_pkg::RST_PWM_MODE));
      rdchk("chan cfg", ps_fault_pkg::OFS_CHAN_CFG, 32'hFF, 32'(ps_fault_pkg::RST_CHAN_CFG));
      rdchk("slope", ps_fault_pkg::OFS_SLOPE, 32'hFFFF, 32'(ps_fault_pkg::RST_SLOPE));
      rdchk("zero", ps_fault_pkg::OFS_ZERO, 32'hFFFF, 32'(ps_fault_pkg::RST_ZERO));
      rdchk("ready idle", ps_fault_pkg::OFS_PADS, 32'hC000, 32'hC000);
      apb(1'b1, 8'h30, $urandom);
      rdchk("unmapped", 8'h30, 32'hFFFFFFFF, 32'h0);
      // Random pulses with the minimum width on, then off
      for (int i = 0; i < 8; i++) begin
         if (i == 4) begin
            apb(1'b1, ps_fault_pkg::OFS_PWM_MODE0, 32'h0);
         end
         w = $urandom_range(4, 1);
         pwmIn <= 2'h1;
         repeat (w) @(posedge core_clk);
         pwmIn <= 2'h0;
         repeat (6) @(posedge core_clk);
         chk("pulse width", 32'(expW(w, i < 4)), 32'(lastWidth));
      end
      // Temperature with random slope; bus 1 is unused yet still answers
      for (int i = 0; i < 4; i++) begin
         s = $urandom_range(15, 1);
         t = $urandom_range(165, 0) - 40;
         adcBus0 <= 12'(int'(ps_fault_pkg::RST_ZERO) + s * t);
         adcBus1 <= 12'(int'(ps_fault_pkg::RST_ZERO) + s * (t / 2));
         apb(1'b1, ps_fault_pkg::OFS_SLOPE, 32'(s));
         rdchk("temp0", ps_fault_pkg::OFS_TEMP0, 32'hFFFF, 32'(expTemp(adcBus0, s)));
         rdchk("temp1", ps_fault_pkg::OFS_TEMP1, 32'hFFFF, 32'(expTemp(adcBus1, s)));
      end
      // Stage UV on channel 0: ignored while disabled, then reported
      uvReq <= 4'h1;
      settle();
      rdchk("ready ignored", ps_fault_pkg::OFS_PADS, 32'h4000, 32'h4000);
      rdchk("uv ignored", ps_fault_pkg::OFS_VOUT_ST0, 32'h90, 32'h0);
      apb(1'b1, ps_fault_pkg::OFS_PWM_MODE0, 32'h1);
      settle();
      rdchk("ready low", ps_fault_pkg::OFS_PADS, 32'h4000, 32'h0);
      rdchk("uv not run", ps_fault_pkg::OFS_VOUT_ST0, 32'h80, 32'h0);
      runCmd <= 2'h1;
      voutUvPin <= 2'h1;
      settle();
      rdchk("uv with vout uv", ps_fault_pkg::OFS_VOUT_ST0, 32'h90, 32'h90);
      uvReq <= 4'h0;
      voutUvPin <= 2'h0;
      runCmd <= 2'h0;
      settle();
      rdchk("ready back", ps_fault_pkg::OFS_PADS, 32'h4000, 32'h4000);
      rdchk("uv latched", ps_fault_pkg::OFS_VOUT_ST0, 32'h90, 32'h90);
      apb(1'b1, ps_fault_pkg::OFS_VOUT_ST0, 32'h90);
      rdchk("uv cleared", ps_fault_pkg::OFS_VOUT_ST0, 32'h90, 32'h0);
      // Stage fault on bus 1 with the rail running
      rdchk("ready before run", ps_fault_pkg::OFS_PADS, 32'h8000, 32'h8000);
      runCmd <= 2'h2;
      faultReq <= 4'h4;
      settle();
      chk("fault off", 32'h0, 32'(outEnable[1]));
      rdchk("fault ov", ps_fault_pkg::OFS_VOUT_ST1, 32'h80, 32'h80);
      rdchk("fault iout", ps_fault_pkg::OFS_IOUT_ST, 32'h10, 32'h10);
      rdchk("fault ready", ps_fault_pkg::OFS_PADS, 32'h8000, 32'h0);
      faultReq <= 4'h0;
      settle();
      chk("no retry", 32'h0, 32'(outEnable[1]));
      rdchk("ready live", ps_fault_pkg::OFS_PADS, 32'h8000, 32'h8000);
      apb(1'b1, ps_fault_pkg::OFS_IOUT_ST, 32'h10);
      rdchk("iout cleared", ps_fault_pkg::OFS_IOUT_ST, 32'h10, 32'h0);
      apb(1'b1, ps_fault_pkg::OFS_VOUT_ST1, 32'h80);
      rdchk("ov1 cleared", ps_fault_pkg::OFS_VOUT_ST1, 32'h80, 32'h0);
      // Drive supply monitor serving both channels
      apb(1'b1, ps_fault_pkg::OFS_CHAN_CFG, 32'h20);
      runCmd <= 2'h3;
      driveMonBelowPin <= 1'b1;
      settle();
      rdchk("drive uv0", ps_fault_pkg::OFS_VOUT_ST0, 32'h80, 32'h80);
      rdchk("drive uv1", ps_fault_pkg::OFS_VOUT_ST1, 32'h80, 32'h80);
      rdchk("drive ready", ps_fault_pkg::OFS_PADS, 32'hC000, 32'h0);
      driveMonBelowPin <= 1'b0;
      runCmd <= 2'h0;
      // Open sense line keeps every output off until a passing retest
      senseOpenPin <= 2'h1;
      apb(1'b1, ps_fault_pkg::OFS_CTRL, 32'h1);
      retest();
      chk("open off", 32'h0, 32'(outEnable));
      rdchk("open flags", ps_fault_pkg::OFS_VOUT_ST0, 32'h90, 32'h90);
      senseOpenPin <= 2'h0;
      settle();
      chk("open held", 32'h0, 32'(outEnable));
      apb(1'b1, ps_fault_pkg::OFS_CTRL, 32'h1);
      retest();
      chk("retest on", 32'h3, 32'(outEnable));
      give_verdict();
   end
endmodule // power_stage_fault_status_bench
